// *** core/mvs_status_core.sv ***
// Motor vector status flags, PWM parameters, sector registers and APB slave.
//
// How it works
// R1: Low-speed flag set when speed below threshold.
// R2: Supply-low flag set when supply below 0x0100.
// R3: Flag when smallest phase gap below setting.
// R4: Bit 5 keeps previous disparity flag.
// R5: Holds 16-bit switching-speed threshold setting.
// R6: Software scales speed by two to fifteen.
// R7: Software copies driver period into period field.
// R8: Minimum disparity setting bounds phase pulse gaps.
// R9: Software gives disparity in counter clock counts.
// R10: Sector field four bits, upper bits zero.
// R11: Sector encodes rotor position, twelve thirty-degree steps.
// R12: Prior-sector field keeps previous sector value.
// R13: Old values copied before each calculation update.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module mvs_status_core (
   input  wire logic                 pclk,               // System clock, 200 MHz.
   input  wire logic                 presetn,            // Asynchronous reset, active low.
   input  wire logic                 ce,                 // Clock enable, freezes all state.
   input  wire mvs_pkg::mvs_apb_req_t apb_req,           // APB request signals.
   output mvs_pkg::mvs_apb_rsp_t     apb_rsp,            // APB answer signals.
   input  wire mvs_pkg::mvs_calc_t   calc,               // Engine results with update strobe.
   output logic                      shift_pwm_active,   // Low speed, shift and 2-phase on.
   output logic                      supply_low,         // Supply-low flag.
   output logic [15:0]               pwm_period_value,   // PWM period for the engine.
   output logic [3:0]                rotor_sector,       // Current output sector.
   output logic [3:0]                prior_sector_value, // Previous sector for input work.
   output logic                      irq                 // Level interrupt.
);

   // ----------------------------------------------------------------------
   // State and helpers
   // ----------------------------------------------------------------------
   mvs_pkg::mvs_state_t s_r;
   mvs_pkg::mvs_state_t s_nxt;

   logic        gap_low;
   logic [3:0]  sector_calc;
   logic        setup;
   logic        access;
   logic        wr;
   logic        mapped;
   logic        upd;
   logic        ls_new;
   logic        sl_new;
   logic [3:0]  irq_event;
   logic [31:0] rd_word;
   logic [15:0] wdata16;

   // ----------------------------------------------------------------------
   // Calculation helpers
   // ----------------------------------------------------------------------
   mvs_pulse_gap #(
      .VW (mvs_pkg::VAL_W)
   ) u_gap (
      .phase_u_compare (calc.cmp_u),
      .phase_v_compare (calc.cmp_v),
      .phase_w_compare (calc.cmp_w),
      .min_gap         (s_r.min_disparity),
      .gap_low         (gap_low)
   );

   mvs_sector_calc u_sec (
      .angle  (calc.angle),
      .sector (sector_calc)
   );

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------

   // Setup and access phases, and whether the address names a register.
   always_comb begin
      setup   = apb_req.psel && !apb_req.penable;
      access  = apb_req.psel && apb_req.penable;
      wdata16 = apb_req.pwdata[15:0];
      unique case (apb_req.paddr)
         mvs_pkg::OFS_STATUS_FLAGS,
         mvs_pkg::OFS_SWITCH_SPEED,
         mvs_pkg::OFS_PWM_PERIOD,
         mvs_pkg::OFS_MIN_DISPARITY,
         mvs_pkg::OFS_SECTOR,
         mvs_pkg::OFS_PRIOR_SECTOR,
         mvs_pkg::OFS_IRQ_STATUS,
         mvs_pkg::OFS_IRQ_MASK: mapped = 1'b1;
         default:               mapped = 1'b0;
      endcase
      wr = ce && access && apb_req.pwrite && mapped;
   end

   // Read word for the addressed register; unused bits read as zero.
   always_comb begin
      rd_word = mvs_pkg::RST_WORD;
      unique case (apb_req.paddr)
         mvs_pkg::OFS_STATUS_FLAGS: begin
            rd_word[mvs_pkg::BIT_LOW_SPEED]      = s_r.low_speed;
            rd_word[mvs_pkg::BIT_LOW_SPEED_PREV] = s_r.low_speed_prev;
            rd_word[mvs_pkg::BIT_SUPPLY_LOW]     = s_r.supply_low;
            rd_word[mvs_pkg::BIT_DISPARITY]      = s_r.disparity;
            rd_word[mvs_pkg::BIT_DISPARITY_PREV] = s_r.disparity_prev;
         end
         mvs_pkg::OFS_SWITCH_SPEED:  rd_word[15:0] = s_r.switch_speed;
         mvs_pkg::OFS_PWM_PERIOD:    rd_word[15:0] = s_r.pwm_period_value;
         mvs_pkg::OFS_MIN_DISPARITY: rd_word[15:0] = s_r.min_disparity;
         mvs_pkg::OFS_SECTOR:        rd_word[3:0]  = s_r.sector;             // [R10]
         mvs_pkg::OFS_PRIOR_SECTOR:  rd_word[3:0]  = s_r.prior_sector_value; // [R12]
         mvs_pkg::OFS_IRQ_STATUS:    rd_word[3:0]  = s_r.irq_status;
         mvs_pkg::OFS_IRQ_MASK:      rd_word[3:0]  = s_r.irq_mask;
         default:                    rd_word       = mvs_pkg::RST_WORD;
      endcase
   end

   // ----------------------------------------------------------------------
   // Calculation update terms
   // ----------------------------------------------------------------------

   // New flag values and the interrupt events they raise.
   always_comb begin
      upd       = ce && calc.strobe;
      ls_new    = (calc.speed < s_r.switch_speed);                // [R1] [R5]
      sl_new    = (calc.dc_supply < mvs_pkg::SUPPLY_LOW_LIMIT);   // [R2]
      irq_event = '0;
      irq_event[mvs_pkg::IRQ_LOW_SPEED_CHG] = upd && (ls_new != s_r.low_speed);
      irq_event[mvs_pkg::IRQ_SUPPLY_LOW]    = upd && sl_new && !s_r.supply_low;
      irq_event[mvs_pkg::IRQ_DISPARITY]     = upd && gap_low && !s_r.disparity;
      irq_event[mvs_pkg::IRQ_SECTOR_UPD]    = upd;
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------

   // Software writes first, then a calculation update overrides them.
   always_comb begin
      s_nxt = s_r;
      if (ce && setup) begin
         s_nxt.prdata  = rd_word;
         s_nxt.pslverr = !mapped;
      end
      if (wr) begin
         unique case (apb_req.paddr)
            mvs_pkg::OFS_STATUS_FLAGS: begin
               s_nxt.low_speed      = apb_req.pwdata[mvs_pkg::BIT_LOW_SPEED];
               s_nxt.low_speed_prev = apb_req.pwdata[mvs_pkg::BIT_LOW_SPEED_PREV];
               s_nxt.supply_low     = apb_req.pwdata[mvs_pkg::BIT_SUPPLY_LOW];
               s_nxt.disparity      = apb_req.pwdata[mvs_pkg::BIT_DISPARITY];
               s_nxt.disparity_prev = apb_req.pwdata[mvs_pkg::BIT_DISPARITY_PREV];
            end
            mvs_pkg::OFS_SWITCH_SPEED:  s_nxt.switch_speed       = wdata16; // [R5]
            mvs_pkg::OFS_PWM_PERIOD:    s_nxt.pwm_period_value   = wdata16; // [R7]
            mvs_pkg::OFS_MIN_DISPARITY: s_nxt.min_disparity      = wdata16; // [R8]
            mvs_pkg::OFS_SECTOR:        s_nxt.sector             = apb_req.pwdata[3:0]; // [R10]
            mvs_pkg::OFS_PRIOR_SECTOR:  s_nxt.prior_sector_value = apb_req.pwdata[3:0];
            mvs_pkg::OFS_IRQ_STATUS:
               s_nxt.irq_status = s_r.irq_status & ~apb_req.pwdata[3:0];
            mvs_pkg::OFS_IRQ_MASK:      s_nxt.irq_mask           = apb_req.pwdata[3:0];
            default:                    s_nxt.prdata             = s_r.prdata;
         endcase
      end
      if (upd) begin
         s_nxt.low_speed_prev     = s_r.low_speed;          // [R13] [R1]
         s_nxt.low_speed          = ls_new;                 // [R1]
         s_nxt.supply_low         = sl_new;                 // [R2]
         s_nxt.disparity_prev     = s_r.disparity;          // [R13] [R4]
         s_nxt.disparity          = gap_low;                // [R3]
         s_nxt.prior_sector_value = s_r.sector;             // [R13] [R12]
         s_nxt.sector             = sector_calc;            // [R11]
      end
      // Events set their sticky bits even in the cycle of a clearing write.
      s_nxt.irq_status = s_nxt.irq_status | irq_event;
   end

   // Registers the whole state; the clock enable holds it unchanged.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.low_speed          <= 1'b0;
         s_r.low_speed_prev     <= 1'b0;
         s_r.supply_low         <= 1'b0;
         s_r.disparity          <= 1'b0;
         s_r.disparity_prev     <= 1'b0;
         s_r.switch_speed       <= mvs_pkg::RST_VALUE16;
         s_r.pwm_period_value   <= mvs_pkg::RST_VALUE16;
         s_r.min_disparity      <= mvs_pkg::RST_VALUE16;
         s_r.sector             <= mvs_pkg::RST_SECTOR;
         s_r.prior_sector_value <= mvs_pkg::RST_SECTOR;
         s_r.irq_status         <= 4'h0;
         s_r.irq_mask           <= 4'h0;
         s_r.prdata             <= mvs_pkg::RST_WORD;
         s_r.pslverr            <= 1'b0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   // Zero-wait answer while enabled; data and error come from flip-flops.
   always_comb begin
      apb_rsp.pready     = ce;
      apb_rsp.pslverr    = s_r.pslverr && access;
      apb_rsp.prdata     = s_r.prdata;
      shift_pwm_active   = s_r.low_speed;                   // [R5]
      supply_low         = s_r.supply_low;
      pwm_period_value   = s_r.pwm_period_value;
      rotor_sector       = s_r.sector;
      prior_sector_value = s_r.prior_sector_value;
      irq                = |(s_r.irq_status & s_r.irq_mask);
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_LOW_SPEED: assert property ( // [R1]
      upd |=> s_r.low_speed == ($past(calc.speed) < $past(s_r.switch_speed)))
      else $error("Low-speed flag does not follow speed against threshold.");

   AST_LOW_SPEED_PREV: assert property ( // [R13]
      upd |=> s_r.low_speed_prev == $past(s_r.low_speed))
      else $error("Previous low-speed bit lost the old flag.");

   AST_SUPPLY_LOW: assert property ( // [R2]
      upd |=> s_r.supply_low == ($past(calc.dc_supply) < 16'h0100))
      else $error("Supply-low flag wrong for supply value.");

   AST_DISPARITY: assert property ( // [R3]
      upd |=> s_r.disparity == $past(gap_low))
      else $error("Disparity flag does not follow the gap check.");

   AST_DISPARITY_PREV: assert property ( // [R4]
      upd |=> s_r.disparity_prev == $past(s_r.disparity))
      else $error("Previous disparity bit lost the old flag.");

   AST_SWITCH_WRITE: assert property ( // [R5]
      wr && apb_req.paddr == mvs_pkg::OFS_SWITCH_SPEED
      |=> s_r.switch_speed == $past(apb_req.pwdata[15:0]))
      else $error("Switching-speed write not stored.");

   AST_SECTOR_RANGE: assert property ( // [R11]
      upd |=> s_r.sector < 4'hc)
      else $error("Computed sector outside twelve sectors.");

   AST_PRIOR_SECTOR: assert property ( // [R12]
      upd |=> s_r.prior_sector_value == $past(s_r.sector))
      else $error("Prior sector does not hold the old sector.");

   AST_SECTOR_READ: assert property ( // [R10]
      ce && setup && apb_req.paddr == mvs_pkg::OFS_SECTOR
      |=> s_r.prdata[31:4] == 28'h0 && s_r.prdata[3:0] == $past(s_r.sector))
      else $error("Sector read shows wrong value or nonzero upper bits.");

endmodule : mvs_status_core

// *** core/mvs_pkg.sv ***
// Package of constants, field layouts and carrier types for the motor vector status block.
package mvs_pkg;

   // ----------------------------------------------------------------------
   // Widths and register offsets (byte addresses, one aligned word each)
   // ----------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned VAL_W  = 16;
   localparam int unsigned SEC_W  = 4;
   localparam int unsigned IRQ_W  = 4;

   localparam logic [7:0] OFS_STATUS_FLAGS   = 8'h00;
   localparam logic [7:0] OFS_SWITCH_SPEED   = 8'h04;
   localparam logic [7:0] OFS_PWM_PERIOD     = 8'h08;
   localparam logic [7:0] OFS_MIN_DISPARITY  = 8'h0c;
   localparam logic [7:0] OFS_SECTOR         = 8'h10;
   localparam logic [7:0] OFS_PRIOR_SECTOR   = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS     = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'h1c;

   // ----------------------------------------------------------------------
   // Field positions of the status flags register
   // ----------------------------------------------------------------------
   localparam int unsigned BIT_LOW_SPEED      = 0;
   localparam int unsigned BIT_LOW_SPEED_PREV = 1;
   localparam int unsigned BIT_SUPPLY_LOW     = 2;
   localparam int unsigned BIT_DISPARITY      = 4;
   localparam int unsigned BIT_DISPARITY_PREV = 5;

   // Interrupt event positions in the status and mask registers.
   localparam int unsigned IRQ_LOW_SPEED_CHG = 0;
   localparam int unsigned IRQ_SUPPLY_LOW    = 1;
   localparam int unsigned IRQ_DISPARITY     = 2;
   localparam int unsigned IRQ_SECTOR_UPD    = 3;

   // ----------------------------------------------------------------------
   // Thresholds and reset values
   // ----------------------------------------------------------------------
   localparam logic [15:0] SUPPLY_LOW_LIMIT = 16'h0100;
   localparam logic [3:0]  SECTOR_COUNT     = 4'hc;
   localparam logic [15:0] RST_VALUE16      = 16'h0000;
   localparam logic [3:0]  RST_SECTOR       = 4'h0;
   localparam logic [31:0] RST_WORD         = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        strobe;
      logic [15:0] speed;
      logic [15:0] dc_supply;
      logic [15:0] cmp_u;
      logic [15:0] cmp_v;
      logic [15:0] cmp_w;
      logic [15:0] angle;
   } mvs_calc_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } mvs_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } mvs_apb_rsp_t;

   typedef struct packed {
      logic        low_speed;
      logic        low_speed_prev;
      logic        supply_low;
      logic        disparity;
      logic        disparity_prev;
      logic [15:0] switch_speed;
      logic [15:0] pwm_period_value;
      logic [15:0] min_disparity;
      logic [3:0]  sector;
      logic [3:0]  prior_sector_value;
      logic [3:0]  irq_status;
      logic [3:0]  irq_mask;
      logic [31:0] prdata;
      logic        pslverr;
   } mvs_state_t;

endpackage : mvs_pkg

// *** core/mvs_pulse_gap.sv ***
// Smallest pairwise gap among the three phase compare values, checked against the setting.
`timescale 1ns/1ps
module mvs_pulse_gap #(
   parameter int unsigned VW = 16
) (
   input  wire logic [VW-1:0] phase_u_compare, // Phase U compare value.
   input  wire logic [VW-1:0] phase_v_compare, // Phase V compare value.
   input  wire logic [VW-1:0] phase_w_compare, // Phase W compare value.
   input  wire logic [VW-1:0] min_gap,         // Smallest allowed gap in counter clocks.
   output logic               gap_low          // High while the smallest gap is below it.
);

   // ----------------------------------------------------------------------
   // Gap computation
   // ----------------------------------------------------------------------
   function automatic logic [VW-1:0] abs_diff(input logic [VW-1:0] a, input logic [VW-1:0] b);
      abs_diff = (a >= b) ? (a - b) : (b - a);
   endfunction : abs_diff

   logic [VW-1:0] gap_uv;
   logic [VW-1:0] gap_vw;
   logic [VW-1:0] gap_wu;
   logic [VW-1:0] gap_min;

   // The smallest of the three gaps decides the flag.
   always_comb begin
      gap_uv  = abs_diff(phase_u_compare, phase_v_compare);
      gap_vw  = abs_diff(phase_v_compare, phase_w_compare);
      gap_wu  = abs_diff(phase_w_compare, phase_u_compare);
      gap_min = (gap_uv < gap_vw) ? gap_uv : gap_vw;
      gap_min = (gap_wu < gap_min) ? gap_wu : gap_min;
      gap_low = (gap_min < min_gap); // [R3] [R8]
   end

endmodule : mvs_pulse_gap

// *** core/mvs_sector_calc.sv ***
// Maps an electrical angle of one full turn onto twelve sectors of thirty degrees.
`timescale 1ns/1ps
module mvs_sector_calc (
   input  wire logic [15:0] angle,  // Rotor angle, full scale is one turn.
   output logic      [3:0]  sector  // Sector number, 0 to 11.
);

   // ----------------------------------------------------------------------
   // Scaling
   // ----------------------------------------------------------------------
   logic [19:0] scaled;

   // Angle times twelve; the upper bits are the sector index.
   always_comb begin
      scaled = 20'(angle) * 20'(mvs_pkg::SECTOR_COUNT);
      sector = scaled[19:16]; // [R11]
   end

endmodule : mvs_sector_calc

// *** tb/mvs_engine_model.sv ***
// Behavioural model of the engine results feed and of the PWM driver period register.
`timescale 1ns/1ps
module mvs_engine_model #(
   parameter logic [15:0] DRV_PERIOD = 16'h0fa0  // Period held by the PWM driver.
) (
   input  wire logic          pclk,          // System clock.
   output mvs_pkg::mvs_calc_t calc,          // Results with update strobe.
   output logic [15:0]        driver_period  // Driver period register value.
);
   // ----------------------------------------------------------------------
   // Driver period and results feed
   // ----------------------------------------------------------------------
   // Software must copy this value into the period field of the block.
   assign driver_period = DRV_PERIOD;

   // The feed starts idle with the strobe low.
   initial begin
      calc = '0;
   end

   // Presents one result set for one cycle, then inverts the data lines.
   // The inversion makes a late sample of released data show as a mismatch.
   task automatic fire(input logic [15:0] spd, dc, u, v, w, ang);
      @(posedge pclk);
      calc <= {1'b1, spd, dc, u, v, w, ang};
      @(posedge pclk);
      calc <= {1'b0, ~spd, ~dc, ~u, ~v, ~w, ~ang};
   endtask : fire
endmodule : mvs_engine_model

// *** tb/mvs_status_core_test.sv ***
// Self-checking testbench of the motor vector status block.
`timescale 1ns/1ps
module mvs_status_core_test;
   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic                  pclk;
   logic                  presetn;
   logic                  ce;
   mvs_pkg::mvs_apb_req_t apb_req;
   mvs_pkg::mvs_apb_rsp_t apb_rsp;
   mvs_pkg::mvs_calc_t    calc;
   logic                  shift_pwm_active;
   logic                  supply_low;
   logic [15:0]           pwm_period_value;
   logic [3:0]            rotor_sector;
   logic [3:0]            prior_sector_value;
   logic                  irq;
   logic [15:0]           driver_period;
   int                    mismatches;
   int                    samples_checked;
   logic [31:0]           rd;
   logic                  err;
   logic [31:0]           exp_flags;
   logic [3:0]            exp_sec;
   logic [3:0]            old_sec;
   logic                  low;
   logic                  lowp;
   logic                  dis;
   logic                  disp;
   // Speed, supply, compare U, V, W and angle of each calculation update.
   logic [15:0] tv [4][6] = '{'{16'h0fff, 16'h00ff, 16'h0100, 16'h010f, 16'h0300, 16'h0000},
                              '{16'h1000, 16'h0100, 16'h0100, 16'h0110, 16'h0300, 16'hffff},
                              '{16'hffff, 16'hffff, 16'h0200, 16'h0200, 16'h0200, 16'h1556},
                              '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'hffff, 16'h8000}};

   mvs_status_core mvs_status_core_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .calc(calc), .shift_pwm_active(shift_pwm_active), .supply_low(supply_low),
      .pwm_period_value(pwm_period_value), .rotor_sector(rotor_sector),
      .prior_sector_value(prior_sector_value), .irq(irq)
   );
   mvs_engine_model mdl_inst (.pclk(pclk), .calc(calc), .driver_period(driver_period));

   // Clock of 200 MHz.
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("Comparisons: %0d, mismatches: %0d.", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // Compares one value and counts the result.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; read data and error are taken at the completing edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (apb_rsp.pready !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED pready expected 1 seen %b", apb_rsp.pready);
         final_report();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   // Reads a register and compares it.
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("register %h", a), exp, rd);
      chk("read error", 32'h0, {31'h0, err});
   endtask : rdchk

   // Absolute difference of two compare values.
   function automatic logic [15:0] gap(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a - b : b - a;
   endfunction : gap

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      apb_req = '0;
      mismatches = 0;
      samples_checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, field widths, read-as-zero bits and an unmapped place.
      for (int i = 0; i < 8; i++) begin
         rdchk(8'(4 * i), 32'h0000_0000);
      end
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'(4 * i), 32'hffff_ffff);
      end
      rdchk(mvs_pkg::OFS_STATUS_FLAGS, 32'h0000_0037);
      rdchk(mvs_pkg::OFS_SWITCH_SPEED, 32'h0000_ffff);
      rdchk(mvs_pkg::OFS_PWM_PERIOD, 32'h0000_ffff);
      rdchk(mvs_pkg::OFS_MIN_DISPARITY, 32'h0000_ffff);
      rdchk(mvs_pkg::OFS_SECTOR, 32'h0000_000f);
      rdchk(mvs_pkg::OFS_PRIOR_SECTOR, 32'h0000_000f);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'(4 * i), 32'h0000_0000);
      end
      apb(1'b1, mvs_pkg::OFS_PWM_PERIOD, {16'h0000, driver_period});
      @(negedge pclk);
      chk("period port", {16'h0, driver_period}, {16'h0, pwm_period_value});
      $display("Test access done.");
      // Calculation updates with flags, sectors and previous values.
      apb(1'b1, mvs_pkg::OFS_SWITCH_SPEED, 32'h0000_1000);
      apb(1'b1, mvs_pkg::OFS_MIN_DISPARITY, 32'h0000_0010);
      apb(1'b1, mvs_pkg::OFS_IRQ_STATUS, 32'h0000_000f);
      old_sec = 4'h0;
      lowp = 1'b0;
      disp = 1'b0;
      for (int i = 0; i < 4; i++) begin
         mdl_inst.fire(tv[i][0], tv[i][1], tv[i][2], tv[i][3], tv[i][4], tv[i][5]);
         low = tv[i][0] < 16'h1000;
         dis = gap(tv[i][2], tv[i][3]) < 16'h0010 || gap(tv[i][3], tv[i][4]) < 16'h0010
               || gap(tv[i][4], tv[i][2]) < 16'h0010;
         exp_flags = {26'h0, disp, dis, 1'b0, tv[i][1] < 16'h0100, lowp, low};
         exp_sec = 4'((32'(tv[i][5]) * 12) >> 16);
         rdchk(mvs_pkg::OFS_STATUS_FLAGS, exp_flags);
         rdchk(mvs_pkg::OFS_SECTOR, {28'h0, exp_sec});
         rdchk(mvs_pkg::OFS_PRIOR_SECTOR, {28'h0, old_sec});
         chk("low speed port", {31'h0, low}, {31'h0, shift_pwm_active});
         chk("supply port", {31'h0, exp_flags[2]}, {31'h0, supply_low});
         chk("sector port", {28'h0, exp_sec}, {28'h0, rotor_sector});
         chk("prior port", {28'h0, old_sec}, {28'h0, prior_sector_value});
         old_sec = exp_sec;
         lowp = low;
         disp = dis;
      end
      $display("Test updates done.");
      // Sticky events, mask and write-one-to-clear.
      rdchk(mvs_pkg::OFS_IRQ_STATUS, 32'h0000_000f);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, mvs_pkg::OFS_IRQ_MASK, 32'h0000_0008);
      @(negedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, mvs_pkg::OFS_IRQ_STATUS, 32'h0000_0008);
      @(negedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rdchk(mvs_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      apb(1'b1, mvs_pkg::OFS_IRQ_MASK, 32'h0000_000f);
      @(negedge pclk);
      chk("irq all mask", 32'h1, {31'h0, irq});
      apb(1'b1, mvs_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      @(negedge pclk);
      chk("irq all clear", 32'h0, {31'h0, irq});
      rdchk(mvs_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
      $display("Test interrupt done.");
      // An update offered while the clock enable is low changes nothing.
      @(posedge pclk);
      ce <= 1'b0;
      mdl_inst.fire(16'h0000, 16'hffff, 16'h0000, 16'h4000, 16'h8000, 16'h4000);
      @(posedge pclk);
      ce <= 1'b1;
      rdchk(mvs_pkg::OFS_SECTOR, {28'h0, old_sec});
      rdchk(mvs_pkg::OFS_STATUS_FLAGS, exp_flags);
      $display("Test enable done.");
      final_report();
   end
endmodule : mvs_status_core_test
